// File: hdl/sbc_map.svh
// Functional notes
// - Async mode: receive polarity bit 1 means the receive line is inverted.
// - Sync mode: same bit 1 inverts the clocked data line, 0 keeps it.
// - Async mode: transmit polarity bit 1 idles transmit low, 0 idles high.
// - Sync mode: bit 1 changes data falling, samples rising; 0 the reverse.
// - Wide select 1 uses high:low divider bytes, 0 uses low byte only.
// - Wake-up: falling receive edge sets receive flag; bit self-clears on rising edge.
// - Wake-up bit 0: receiver assembles characters normally while the auto-baud bit is 0.
// - After reset the divider is 8-bit wide.
// - Any divider byte write restarts the baud timer at once.
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_OFS_CTRL 8'h00
`define SBC_OFS_DIV_LO 8'h04
`define SBC_OFS_DIV_HI 8'h08
`define SBC_OFS_MODE 8'h0c
`define SBC_OFS_STATUS 8'h10
`define SBC_OFS_MASK 8'h14
`define SBC_OFS_RXDATA 8'h18
`define SBC_OFS_TXDATA 8'h1c
`define SBC_BIT_DRP 5
`define SBC_BIT_CTP 4
`define SBC_BIT_WIDE 3
`define SBC_BIT_WAKE 1
`define SBC_BIT_AUTOBAUD 0
`define SBC_CTRL_MASK 8'h3b
`define SBC_CTRL_RESET 8'h00
`define SBC_MODE_SYNC 0
`define SBC_MODE_SRX 1
`define SBC_MODE_BUSY 2
`define SBC_ST_RX 0
`define SBC_ST_TX 1
`define SBC_ST_ABD 2
`define SBC_ST_FERR 3
`define SBC_ST_W 4
`define SBC_OS_LAST 4'hf
`define SBC_OS_MID 4'h7
`define SBC_ABD_SHIFT 7
`define SBC_ABD_EDGES 3'h5
`endif

// File: hdl/sbc_pkg.sv
package sbc_pkg;
  typedef enum logic [1:0] {
    SBC_RX_IDLE = 2'b00,
    SBC_RX_START = 2'b01,
    SBC_RX_DATA = 2'b10,
    SBC_RX_STOP = 2'b11
  } sbc_rx_e;
  typedef enum logic [1:0] {
    SBC_TX_IDLE = 2'b00,
    SBC_TX_ASYNC = 2'b01,
    SBC_TX_SYNC = 2'b10
  } sbc_tx_e;
endpackage : sbc_pkg

// File: hdl/sbc_baud_gen.sv
`timescale 1ns/100ps
module sbc_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic [DIV_W-1:0] divider,
  input wire logic wide,
  input wire logic restart,
  // Rate enable
  output logic tick
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  generate
    if (DIV_W != 16)
    begin : g_chk
      $error("sbc_baud_gen: DIV_W must be 16");
    end
  endgenerate

  assign limit = wide ? divider : {{(DIV_W-8){1'b0}}, divider[7:0]};

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (restart)
    begin
      // Restart drops any partial period
      count <= '0;
      tick <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= '0;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

  property p_restart_clears;
    @(posedge mclk) disable iff (!reset_n)
    restart |=> (count == '0) && !tick;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("baud timer not cleared by divider write");

  property p_narrow_period;
    @(posedge mclk) disable iff (!reset_n)
    (!wide && !restart && count == {{(DIV_W-8){1'b0}}, divider[7:0]}) |=> tick;
  endproperty
  a_narrow_period: assert property (p_narrow_period)
    else $error("narrow divider period wrong");
endmodule : sbc_baud_gen

// File: hdl/sbc_top.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "sbc_map.svh"
module sbc_top #(
  parameter int ABD_CNT_W = 24
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rx_pin,
  output logic tx_pin,
  output logic sync_clk,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  // Interrupt
  output logic irq
);
  logic [7:0] ctrl;
  logic [7:0] divider_low_byte;
  logic [7:0] divider_high_byte;
  logic [1:0] mode;
  logic [`SBC_ST_W-1:0] status;
  logic [`SBC_ST_W-1:0] mask;
  logic [7:0] rx_data;
  logic rx_s1, rx_s2, rx_prev;
  logic din_s1, din_s2;
  logic tick, div_restart, hw_div_wr, wake_armed;
  logic [15:0] hw_div;
  sbc_pkg::sbc_rx_e rx_state;
  sbc_pkg::sbc_tx_e tx_state;
  logic [3:0] rx_os, tx_os;
  logic [2:0] rx_bits;
  logic [3:0] tx_bits;
  logic [7:0] rx_sh;
  logic [9:0] tx_sh;
  logic [7:0] sy_sh;
  logic [ABD_CNT_W-1:0] abd_cnt;
  logic [2:0] abd_falls;
  logic [`SBC_ST_W-1:0] next_status_set;

  generate
    if (ABD_CNT_W < 23)
    begin : g_chk
      $error("sbc_top: ABD_CNT_W must be at least 23");
    end
  endgenerate

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  wire apb_done = psel && penable && pready;
  wire wr = apb_done && pwrite;
  wire sync_mode = mode[`SBC_MODE_SYNC];
  wire drp = ctrl[`SBC_BIT_DRP];
  wire ctp = ctrl[`SBC_BIT_CTP];
  wire wake_en = ctrl[`SBC_BIT_WAKE];
  wire abd_en = ctrl[`SBC_BIT_AUTOBAUD];
  wire rx_level = rx_s2 ^ drp;
  wire rx_last = rx_prev ^ drp;
  wire rx_fall = rx_last && !rx_level;
  wire rx_rise = !rx_last && rx_level;
  wire din_level = din_s2 ^ drp;
  wire wake_mode = !sync_mode && wake_en;
  wire abd_mode = !sync_mode && abd_en && !wake_en;
  wire sw_div_wr = wr && (addr_hit(paddr, `SBC_OFS_DIV_LO) || addr_hit(paddr, `SBC_OFS_DIV_HI));
  wire tx_start = wr && addr_hit(paddr, `SBC_OFS_TXDATA) && tx_state == sbc_pkg::SBC_TX_IDLE;
  wire sy_lead = tick && tx_state == sbc_pkg::SBC_TX_SYNC && sync_clk == ctp;
  wire sy_trail = tick && tx_state == sbc_pkg::SBC_TX_SYNC && sync_clk != ctp;
  wire abd_end = abd_mode && rx_fall && abd_falls == `SBC_ABD_EDGES - 3'h1;
  assign div_restart = sw_div_wr || hw_div_wr;

  sbc_baud_gen #(
    .DIV_W(16)
  ) u_baud (
    .mclk(mclk),
    .reset_n(reset_n),
    .divider({divider_high_byte, divider_low_byte}),
    .wide(ctrl[`SBC_BIT_WIDE]),
    .restart(div_restart),
    .tick(tick)
  );

  // Pin synchronisers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end
    else
    begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
      din_s1 <= data_in;
      din_s2 <= din_s1;
    end
  end

  // APB answer: one wait state, so outputs stay registered
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= paddr[1:0] != 2'h0 || paddr > `SBC_OFS_TXDATA;
      prdata <= 32'h00000000;
      if (!pwrite)
      begin
        case (paddr)
          `SBC_OFS_CTRL: prdata <= {24'h000000, ctrl & `SBC_CTRL_MASK};
          `SBC_OFS_DIV_LO: prdata <= {24'h000000, divider_low_byte};
          `SBC_OFS_DIV_HI: prdata <= {24'h000000, divider_high_byte};
          `SBC_OFS_MODE: prdata <= {29'h00000000, tx_state != sbc_pkg::SBC_TX_IDLE, mode};
          `SBC_OFS_STATUS: prdata <= {28'h0000000, status};
          `SBC_OFS_MASK: prdata <= {28'h0000000, mask};
          `SBC_OFS_RXDATA: prdata <= {24'h000000, rx_data};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register; hardware self-clears win only when software is silent
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= `SBC_CTRL_RESET;
      mode <= 2'h0;
      mask <= '0;
    end
    else
    begin
      if (wr && addr_hit(paddr, `SBC_OFS_CTRL))
      begin
        ctrl <= pwdata[7:0] & `SBC_CTRL_MASK;
      end
      else
      begin
        if (wake_mode && wake_armed && rx_rise)
        begin
          ctrl[`SBC_BIT_WAKE] <= 1'b0;
        end
        if (abd_end)
        begin
          ctrl[`SBC_BIT_AUTOBAUD] <= 1'b0;
        end
      end
      if (wr && addr_hit(paddr, `SBC_OFS_MODE))
      begin
        mode <= pwdata[1:0];
      end
      if (wr && addr_hit(paddr, `SBC_OFS_MASK))
      begin
        mask <= pwdata[`SBC_ST_W-1:0];
      end
    end
  end

  // Divider bytes, also loaded by auto-baud
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divider_low_byte <= 8'h00;
      divider_high_byte <= 8'h00;
    end
    else if (hw_div_wr)
    begin
      divider_low_byte <= hw_div[7:0];
      divider_high_byte <= hw_div[15:8];
    end
    else if (wr && addr_hit(paddr, `SBC_OFS_DIV_LO))
    begin
      divider_low_byte <= pwdata[7:0];
    end
    else if (wr && addr_hit(paddr, `SBC_OFS_DIV_HI))
    begin
      divider_high_byte <= pwdata[7:0];
    end
  end

  // Auto-baud: 0x55 gives five falling edges over eight bit times
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      abd_cnt <= '0;
      abd_falls <= 3'h0;
      hw_div_wr <= 1'b0;
      hw_div <= 16'h0000;
    end
    else
    begin
      hw_div_wr <= 1'b0;
      if (!abd_mode)
      begin
        abd_cnt <= '0;
        abd_falls <= 3'h0;
      end
      else if (abd_end)
      begin
        // Result assumes 16x oversampling in wide mode
        hw_div <= abd_cnt[`SBC_ABD_SHIFT+15:`SBC_ABD_SHIFT] - 16'h0001;
        hw_div_wr <= 1'b1;
        abd_falls <= 3'h0;
      end
      else
      begin
        if (rx_fall)
        begin
          abd_falls <= abd_falls + 3'h1;
        end
        if ((abd_falls != 3'h0 || rx_fall) && abd_cnt != '1)
        begin
          abd_cnt <= abd_cnt + 1'b1;
        end
      end
    end
  end

  // Wake-up edge tracking
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_armed <= 1'b0;
    end
    else if (!wake_mode)
    begin
      wake_armed <= 1'b0;
    end
    else if (rx_fall)
    begin
      wake_armed <= 1'b1;
    end
  end

  // Asynchronous receiver, held off during wake-up and auto-baud
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state <= sbc_pkg::SBC_RX_IDLE;
      rx_os <= 4'h0;
      rx_bits <= 3'h0;
      rx_sh <= 8'h00;
      rx_data <= 8'h00;
    end
    else if (sync_mode || wake_en || abd_en)
    begin
      rx_state <= sbc_pkg::SBC_RX_IDLE;
    end
    else
    begin
      if (tick && rx_state != sbc_pkg::SBC_RX_IDLE)
      begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_state)
        sbc_pkg::SBC_RX_IDLE:
        begin
          if (rx_fall)
          begin
            rx_state <= sbc_pkg::SBC_RX_START;
            rx_os <= 4'h0;
          end
        end
        sbc_pkg::SBC_RX_START:
        begin
          if (tick && rx_os == `SBC_OS_MID)
          begin
            rx_os <= 4'h0;
            rx_bits <= 3'h0;
            rx_state <= rx_level ? sbc_pkg::SBC_RX_IDLE : sbc_pkg::SBC_RX_DATA;
          end
        end
        sbc_pkg::SBC_RX_DATA:
        begin
          if (tick && rx_os == `SBC_OS_LAST)
          begin
            rx_sh <= {rx_level, rx_sh[7:1]};
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == 3'h7)
            begin
              rx_state <= sbc_pkg::SBC_RX_STOP;
            end
          end
        end
        sbc_pkg::SBC_RX_STOP:
        begin
          if (tick && rx_os == `SBC_OS_LAST)
          begin
            rx_state <= sbc_pkg::SBC_RX_IDLE;
            if (rx_level)
            begin
              rx_data <= rx_sh;
            end
          end
        end
        default: rx_state <= sbc_pkg::SBC_RX_IDLE;
      endcase
    end
  end

  // Transmitter: async frame or sync master transfer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_state <= sbc_pkg::SBC_TX_IDLE;
      tx_os <= 4'h0;
      tx_bits <= 4'h0;
      tx_sh <= 10'h3ff;
      sy_sh <= 8'h00;
      sync_clk <= 1'b0;
      data_out <= 1'b0;
      data_oe <= 1'b0;
      tx_pin <= 1'b1;
    end
    else
    begin
      tx_pin <= (sync_mode ? 1'b1 : tx_sh[0]) ^ ctp;
      case (tx_state)
        sbc_pkg::SBC_TX_IDLE:
        begin
          sync_clk <= ctp;
          data_oe <= 1'b0;
          tx_sh <= 10'h3ff;
          if (tx_start)
          begin
            tx_os <= 4'h0;
            tx_bits <= 4'h0;
            if (sync_mode)
            begin
              tx_state <= sbc_pkg::SBC_TX_SYNC;
              sy_sh <= pwdata[7:0];
              data_oe <= !mode[`SBC_MODE_SRX];
            end
            else
            begin
              tx_state <= sbc_pkg::SBC_TX_ASYNC;
              tx_sh <= {1'b1, pwdata[7:0], 1'b0};
            end
          end
        end
        sbc_pkg::SBC_TX_ASYNC:
        begin
          if (tick)
          begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `SBC_OS_LAST)
            begin
              tx_sh <= {1'b1, tx_sh[9:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits == 4'h9)
              begin
                tx_state <= sbc_pkg::SBC_TX_IDLE;
              end
            end
          end
        end
        sbc_pkg::SBC_TX_SYNC:
        begin
          if (tick)
          begin
            sync_clk <= !sync_clk;
          end
          if (sy_lead)
          begin
            data_out <= sy_sh[tx_bits[2:0]] ^ drp;
          end
          if (sy_trail)
          begin
            sy_sh[tx_bits[2:0]] <= din_level;
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == 4'h7)
            begin
              tx_state <= sbc_pkg::SBC_TX_IDLE;
            end
          end
        end
        default: tx_state <= sbc_pkg::SBC_TX_IDLE;
      endcase
    end
  end

  // Sticky status; a set in the clearing cycle survives
  always_comb
  begin
    next_status_set = '0;
    next_status_set[`SBC_ST_RX] = (wake_mode && rx_fall) ||
      (rx_state == sbc_pkg::SBC_RX_STOP && tick && rx_os == `SBC_OS_LAST && rx_level) ||
      (sy_trail && tx_bits == 4'h7 && mode[`SBC_MODE_SRX]);
    next_status_set[`SBC_ST_TX] = (tx_state == sbc_pkg::SBC_TX_ASYNC && tick &&
      tx_os == `SBC_OS_LAST && tx_bits == 4'h9) || (sy_trail && tx_bits == 4'h7);
    next_status_set[`SBC_ST_ABD] = abd_end;
    next_status_set[`SBC_ST_FERR] = rx_state == sbc_pkg::SBC_RX_STOP && tick &&
      rx_os == `SBC_OS_LAST && !rx_level;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && addr_hit(paddr, `SBC_OFS_STATUS))
      begin
        status <= (status & ~pwdata[`SBC_ST_W-1:0]) | next_status_set;
      end
      else
      begin
        status <= status | next_status_set;
      end
      irq <= |(status & mask);
    end
  end

  property p_wake_flag;
    @(posedge mclk) disable iff (!reset_n)
    (wake_mode && rx_fall) |=> status[`SBC_ST_RX];
  endproperty
  a_wake_flag: assert property (p_wake_flag)
    else $error("wake edge did not set receive flag");

  property p_wake_clear;
    @(posedge mclk) disable iff (!reset_n)
    (wake_mode && wake_armed && rx_rise && !wr) |=> !ctrl[`SBC_BIT_WAKE];
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake-up enable did not self-clear");

  property p_wake_no_rx;
    @(posedge mclk) disable iff (!reset_n)
    wake_en |=> rx_state == sbc_pkg::SBC_RX_IDLE;
  endproperty
  a_wake_no_rx: assert property (p_wake_no_rx)
    else $error("receiver ran during wake-up");

  property p_rx_start;
    @(posedge mclk) disable iff (!reset_n)
    (rx_state == sbc_pkg::SBC_RX_IDLE && rx_fall && !sync_mode && !wake_en && !abd_en)
      |=> rx_state == sbc_pkg::SBC_RX_START;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("receiver missed start edge");

  property p_tx_idle;
    @(posedge mclk) disable iff (!reset_n)
    (tx_state == sbc_pkg::SBC_TX_IDLE && !sync_mode && !tx_start) [*2]
      |-> tx_pin == !$past(ctp);
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit idle level wrong");

  property p_sync_lead;
    @(posedge mclk) disable iff (!reset_n)
    sy_lead |=> sync_clk != ctp && data_out == (sy_sh[$past(tx_bits[2:0])] ^ drp);
  endproperty
  a_sync_lead: assert property (p_sync_lead)
    else $error("sync data not changed on leading edge");

  property p_abd_done;
    @(posedge mclk) disable iff (!reset_n)
    (abd_end && !wr) |=> !ctrl[`SBC_BIT_AUTOBAUD] && hw_div_wr ##1 status[`SBC_ST_ABD];
  endproperty
  a_abd_done: assert property (p_abd_done)
    else $error("auto-baud completion wrong");

  property p_reset_narrow;
    @(posedge mclk) $rose(reset_n) |-> !ctrl[`SBC_BIT_WIDE];
  endproperty
  a_reset_narrow: assert property (p_reset_narrow)
    else $error("divider not narrow after reset");

  property p_irq;
    @(posedge mclk) disable iff (!reset_n)
    ##1 irq == $past(|(status & mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output wrong");

  c_rx_char: cover property (@(posedge mclk) disable iff (!reset_n)
    rx_state == sbc_pkg::SBC_RX_STOP ##1 status[`SBC_ST_RX]);
  c_wake: cover property (@(posedge mclk) disable iff (!reset_n) $fell(wake_en));
  c_abd: cover property (@(posedge mclk) disable iff (!reset_n) abd_end);
  c_sync: cover property (@(posedge mclk) disable iff (!reset_n)
    $fell(tx_state == sbc_pkg::SBC_TX_SYNC));
endmodule : sbc_top

// File: testbench/sbc_line_model.sv
`timescale 1ns/100ps
module sbc_line_model (
  // Clock
  input wire logic mclk,
  // Async pins
  output logic rx_pin,
  input wire logic tx_pin,
  // Sync pins
  input wire logic sync_clk,
  input wire logic data_out,
  input wire logic data_oe,
  output logic data_in
);
  initial
  begin
    rx_pin = 1'b1;
  end
  // Released data line shows a changing pattern, never a stale bit
  always_ff @(posedge mclk)
    data_in <= data_oe ? data_out : (data_in !== 1'b1);
  task idle(input logic inv);
    @(posedge mclk);
    rx_pin <= ~inv;
  endtask : idle
  task pulse();
    @(posedge mclk);
    rx_pin <= 1'b0;
    repeat (30) @(posedge mclk);
    rx_pin <= 1'b1;
  endtask : pulse
  task send(input logic [7:0] b, input int bc, input logic inv);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      rx_pin <= f[i] ^ inv;
      repeat (bc - 1) @(posedge mclk);
    end
  endtask : send
  task rx_async(output logic [7:0] b, input int bc);
    do
    begin
      @(posedge mclk);
    end while (tx_pin !== 1'b0);
    repeat (bc + bc / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = tx_pin;
      repeat (bc) @(posedge mclk);
    end
  endtask : rx_async
  // Samples on the edge that returns the clock to its idle level
  task rx_sync(output logic [7:0] b, input logic ctp, input logic drp);
    logic prev;
    for (int i = 0; i < 8; i++)
    begin
      do
      begin
        prev = sync_clk;
        @(posedge mclk);
      end while (!(prev !== ctp && sync_clk === ctp));
      b[i] = data_oe ? (data_out ^ drp) : 1'bx;
    end
  endtask : rx_sync
endmodule : sbc_line_model

// File: testbench/tb_sbc_top.sv
`timescale 1ns/100ps
`include "sbc_map.svh"
module tb_sbc_top;
  logic mclk, reset_n, psel, penable, pwrite, er;
  logic [7:0] paddr, b, d;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rx_pin, tx_pin, sync_clk, data_in, data_out, data_oe, irq;
  int num_errors, checks_done, cyc, len;
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  sbc_top #(.ABD_CNT_W(24)) DUT (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .sync_clk(sync_clk), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .irq(irq));
  sbc_line_model line (.mclk(mclk), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .sync_clk(sync_clk), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  task end_sim();
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp, "register read");
  endtask : rdc
  task tx_wait();
    do
    begin
      apb(1'b0, `SBC_OFS_MODE, 32'h0);
    end while (rd[`SBC_MODE_BUSY] !== 1'b0);
  endtask : tx_wait
  // Cycles from now until the start bit has ended
  task meas(output int n);
    logic low;
    low = 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (tx_pin === 1'b0)
        low = 1'b1;
    end while (!(low && tx_pin === 1'b1) && n < 20000);
  endtask : meas
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(`SBC_OFS_CTRL, 32'h0);
    rdc(`SBC_OFS_DIV_LO, 32'h0);
    rdc(`SBC_OFS_DIV_HI, 32'h0);
    check(tx_pin, 1'b1, "idle high");
    apb(1'b1, `SBC_OFS_CTRL, 32'hff);
    rdc(`SBC_OFS_CTRL, 32'h3b);
    apb(1'b1, `SBC_OFS_CTRL, 32'h10);
    repeat (2) @(posedge mclk);
    check(tx_pin, 1'b0, "idle low");
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped read");
    // Wide divider 256: first bit is 15 ticks of 257 plus the tick phase
    apb(1'b1, `SBC_OFS_CTRL, 32'h08);
    apb(1'b1, `SBC_OFS_DIV_HI, 32'h1);
    apb(1'b1, `SBC_OFS_DIV_LO, 32'h0);
    apb(1'b1, `SBC_OFS_TXDATA, 32'hff);
    meas(len);
    check(len >= 4100 && len <= 4120, 1'b1, "wide rate");
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(`SBC_OFS_CTRL, 32'h0);
    check(tx_pin, 1'b1, "idle after reset");
    // Rewrite mid-period; a stale count would tick about 44 cycles early
    apb(1'b1, `SBC_OFS_DIV_HI, 32'h1);
    apb(1'b1, `SBC_OFS_DIV_LO, 32'h60);
    repeat (40) @(posedge mclk);
    apb(1'b1, `SBC_OFS_DIV_LO, 32'h40);
    apb(1'b1, `SBC_OFS_TXDATA, 32'hff);
    meas(len);
    check(len >= 1035 && len <= 1043, 1'b1, "restart");
    tx_wait();
    apb(1'b1, `SBC_OFS_DIV_LO, 32'h3);
    apb(1'b1, `SBC_OFS_CTRL, 32'h00);
    fork
      apb(1'b1, `SBC_OFS_TXDATA, 32'ha5);
      line.rx_async(b, 64);
    join
    check(b, 8'ha5, "narrow frame");
    tx_wait();
    for (int i = 1; i >= 0; i--)
    begin
      d = i ? 8'h3c : 8'hc3;
      apb(1'b1, `SBC_OFS_CTRL, {26'h0, i[0], 5'h1});
      line.idle(i[0]);
      apb(1'b1, `SBC_OFS_CTRL, {26'h0, i[0], 5'h0});
      apb(1'b1, `SBC_OFS_STATUS, 32'hff);
      apb(1'b1, `SBC_OFS_MASK, 32'h1);
      line.send(d, 64, i[0]);
      repeat (20) @(posedge mclk);
      rdc(`SBC_OFS_RXDATA, {24'h0, d});
      check(irq, 1'b1, "irq raised");
      apb(1'b1, `SBC_OFS_MASK, 32'h0);
      repeat (2) @(posedge mclk);
      check(irq, 1'b0, "irq masked");
      apb(1'b1, `SBC_OFS_STATUS, 32'hff);
      rdc(`SBC_OFS_STATUS, 32'h0);
    end
    apb(1'b1, `SBC_OFS_CTRL, 32'h02);
    line.pulse();
    repeat (8) @(posedge mclk);
    apb(1'b0, `SBC_OFS_STATUS, 32'h0);
    check(rd[`SBC_ST_RX], 1'b1, "wake flag");
    rdc(`SBC_OFS_CTRL, 32'h0);
    rdc(`SBC_OFS_RXDATA, 32'hc3);
    apb(1'b1, `SBC_OFS_STATUS, 32'hff);
    apb(1'b1, `SBC_OFS_CTRL, 32'h09);
    line.send(8'h55, 72, 1'b0);
    repeat (10) @(posedge mclk);
    rdc(`SBC_OFS_CTRL, 32'h08);
    rdc(`SBC_OFS_DIV_LO, (8 * 72) / 128 - 1);
    rdc(`SBC_OFS_DIV_HI, 32'h0);
    apb(1'b0, `SBC_OFS_STATUS, 32'h0);
    check(rd[`SBC_ST_ABD], 1'b1, "autobaud done");
    apb(1'b1, `SBC_OFS_MODE, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `SBC_OFS_CTRL, {26'h0, k[1], k[0], 4'h8});
      repeat (2) @(posedge mclk);
      check(sync_clk, k[0], "clock idle");
      fork
        apb(1'b1, `SBC_OFS_TXDATA, 32'h96);
        line.rx_sync(b, k[0], k[1]);
      join
      check(b, 8'h96, "sync data");
      tx_wait();
    end
    end_sim();
  end
endmodule : tb_sbc_top
